// File: logic/lfp_pkg.sv
// package: constants and types for the led driver fault protection block
package lfp_pkg;
   // clock rate in kHz
   localparam int CLK_KHZ = 100000;
   // sync pin low time before shutdown, in us
   localparam int SYNC_LOW_US = 7;
   localparam int SYNC_LOW_CYC = SYNC_LOW_US * CLK_KHZ / 1000;
   // enable low cycles before low power shutdown (switching clock cycles)
   localparam int EN_LOW_CYC = 32750;
   // undervoltage fall filter, in us
   localparam int UV_FILT_US = 50;
   localparam int UV_FILT_CYC = UV_FILT_US * CLK_KHZ / 1000;
   // 1x input overcurrent timer, in switching cycles
   localparam int OC1_CYC = 10000;
   // 2x input overcurrent shutdown limit, in us
   localparam int OC2_US = 3;
   localparam int OC2_CYC = OC2_US * CLK_KHZ / 1000;
   // operating states, gray coded along off, detect, run
   typedef enum logic [1:0] {
      LFP_OFF    = 2'b00,
      LFP_DETECT = 2'b01,
      LFP_RUN    = 2'b11,
      LFP_LATCH  = 2'b10
   } lfp_state_t;
endpackage

// File: logic/lfp_fault_ctrl.sv
// module: fault protection sequencer for a boost led driver
// Operation
// R01: primary overvoltage stops boost switching immediately
// R02: open string on overvoltage is dropped
// R03: boost resumes when overvoltage clears, unlatched
// R04: switch node overvoltage latches everything off
// R05: latch clears only by shutdown or undervoltage
// R06: string detection completes before boost starts
// R07: current limit ends on-time for one cycle
// R08: secondary switch current limit shuts down immediately
// R09: 1x overcurrent constant current, bounded cycle count
// R10: fault output asserts on entering 1x mode
// R11: 1x clears early, fault drops, normal resumes
// R12: sync pin low past 7us shuts down
// R13: enable low 32750 cycles enters low power
// R14: 2x overcurrent shuts down within 3us
// R15: 2x overcurrent shutdown latches, fault asserted
// R16: low power entry clears all fault latches
// R17: undervoltage disables only after 50us filter
// R18: 1x timer expiry latches off, fault held
`timescale 1ns/1ns
module lfp_fault_ctrl #(
   parameter int NUM_STRINGS = 4,
   parameter int EN_LOW_CYCLES = lfp_pkg::EN_LOW_CYC,
   parameter int OC1_CYCLES = lfp_pkg::OC1_CYC,
   parameter int UV_CYCLES = lfp_pkg::UV_FILT_CYC
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // switching cycle start pulse from oscillator
   input wire logic sw_cycle_in,
   // host pins
   input wire logic enable_dim_pin_in,
   input wire logic freq_set_sync_pin_in,
   // analog comparator outputs
   input wire logic ovp_trip_in,
   input wire logic switch_node_ovp_in,
   input wire logic sw_ilim_in,
   input wire logic sw_ilim2_in,
   input wire logic in_oc1x_in,
   input wire logic in_oc2x_in,
   input wire logic uv_fall_in,
   input wire logic [NUM_STRINGS-1:0] string_open_in,
   input wire logic detect_done_in,
   // outputs
   output logic boost_gate_en_out,
   output logic [NUM_STRINGS-1:0] led_sink_pins_en_out,
   output logic disconnect_on_out,
   output logic disconnect_cc_out,
   output logic fault_n_out,
   output logic low_power_out
);
   localparam int EW = $clog2(EN_LOW_CYCLES + 1);
   localparam int OW = $clog2(OC1_CYCLES + 1);
   localparam int UW = $clog2(UV_CYCLES + 1);
   localparam int SYW = $clog2(lfp_pkg::SYNC_LOW_CYC + 1);
   // 2x shutdown deadline in clocks, used as a delay bound below
   localparam int OC2_LIM = lfp_pkg::OC2_CYC;

   // three stage synchronisers for pins and comparators
   logic [2:0] en_s, sy_s, ov_s, sn_s, il_s, i2_s, o1_s, o2_s, uv_s;
   logic [2:0] dd_s;
   logic [NUM_STRINGS-1:0] so_s1, so_s2, so_s3, so_f, next_so_f;
   logic en_f, sy_f, ov_f, sn_f, il_f, i2_f, o1_f, o2_f, uv_f, dd_f;
   logic next_en_f, next_sy_f, next_ov_f, next_sn_f, next_il_f;
   logic next_i2_f, next_o1_f, next_o2_f, next_uv_f, next_dd_f;

   // a level moves once stages two and three agree
   function automatic logic filt(input logic [2:0] s, input logic cur);
      filt = (s[1] == s[2]) ? s[2] : cur;
   endfunction

   always_comb begin
      next_en_f = filt(en_s, en_f);
      next_sy_f = filt(sy_s, sy_f);
      next_ov_f = filt(ov_s, ov_f);
      next_sn_f = filt(sn_s, sn_f);
      next_il_f = filt(il_s, il_f);
      next_i2_f = filt(i2_s, i2_f);
      next_o1_f = filt(o1_s, o1_f);
      next_o2_f = filt(o2_s, o2_f);
      next_uv_f = filt(uv_s, uv_f);
      next_dd_f = filt(dd_s, dd_f);
      // open string flags move as one word once stages two and three agree
      next_so_f = (so_s2 == so_s3) ? so_s3 : so_f;
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         {en_s, ov_s, sn_s, il_s} <= '0;
         // sync stages start at the filtered level, so no false low count
         sy_s <= 3'h7;
         {i2_s, o1_s, o2_s, uv_s, dd_s} <= '0;
         so_s1 <= '0;
         so_s2 <= '0;
         so_s3 <= '0;
         so_f <= '0;
         {en_f, ov_f, sn_f, il_f, i2_f, o1_f, o2_f, uv_f, dd_f} <= '0;
         sy_f <= 1'b1;
      end else begin
         en_s <= {en_s[1:0], enable_dim_pin_in};
         sy_s <= {sy_s[1:0], freq_set_sync_pin_in};
         ov_s <= {ov_s[1:0], ovp_trip_in};
         sn_s <= {sn_s[1:0], switch_node_ovp_in};
         il_s <= {il_s[1:0], sw_ilim_in};
         i2_s <= {i2_s[1:0], sw_ilim2_in};
         o1_s <= {o1_s[1:0], in_oc1x_in};
         o2_s <= {o2_s[1:0], in_oc2x_in};
         uv_s <= {uv_s[1:0], uv_fall_in};
         dd_s <= {dd_s[1:0], detect_done_in};
         so_s1 <= string_open_in;
         so_s2 <= so_s1;
         so_s3 <= so_s2;
         so_f <= next_so_f;
         en_f <= next_en_f;
         sy_f <= next_sy_f;
         ov_f <= next_ov_f;
         sn_f <= next_sn_f;
         il_f <= next_il_f;
         i2_f <= next_i2_f;
         o1_f <= next_o1_f;
         o2_f <= next_o2_f;
         uv_f <= next_uv_f;
         dd_f <= next_dd_f;
      end
   end

   // sequencer state, counters and latches
   lfp_pkg::lfp_state_t state, next_state;
   logic [EW-1:0] en_cnt, next_en_cnt;
   logic [OW-1:0] oc_cnt, next_oc_cnt;
   logic [UW-1:0] uv_cnt, next_uv_cnt;
   logic [SYW-1:0] sy_cnt, next_sy_cnt;
   logic [NUM_STRINGS-1:0] dropped, next_dropped;
   logic lp, next_lp, uv_off, next_uv_off, sy_off, next_sy_off;
   logic cut, next_cut;
   logic boost, next_boost, disc, next_disc, cc, next_cc;
   logic flt_n, next_flt_n;
   logic [NUM_STRINGS-1:0] sinks, next_sinks;
   logic shutdown;

   // shutdown that clears latches: long enable low or filtered undervoltage
   assign shutdown = lp | uv_off;

   always_comb begin
      next_state = state;
      next_en_cnt = en_cnt;
      next_oc_cnt = oc_cnt;
      next_uv_cnt = uv_cnt;
      next_sy_cnt = sy_cnt;
      next_dropped = dropped;
      next_lp = lp;
      next_uv_off = uv_off;
      next_sy_off = sy_off;
      next_cut = cut;
      // enable low counted in switching cycles; high wakes the device
      if (en_f) begin
         next_en_cnt = '0;
         next_lp = 1'b0;
      end else if (sw_cycle_in && en_cnt < EW'(EN_LOW_CYCLES)) begin
         next_en_cnt = en_cnt + 1'b1; // see R13
      end
      if (!en_f && en_cnt >= EW'(EN_LOW_CYCLES))
         next_lp = 1'b1; // see R13
      // undervoltage must persist for the filter time
      if (!uv_f) begin
         next_uv_cnt = '0;
         next_uv_off = 1'b0;
      end else if (uv_cnt < UW'(UV_CYCLES)) begin
         next_uv_cnt = uv_cnt + 1'b1; // see R17
      end else begin
         next_uv_off = 1'b1; // see R17
      end
      // sync low watchdog; release lets the device resume run without a new detection
      if (sy_f) begin
         next_sy_cnt = '0;
         next_sy_off = 1'b0;
      end else if (sy_cnt < SYW'(lfp_pkg::SYNC_LOW_CYC)) begin
         next_sy_cnt = sy_cnt + 1'b1;
      end else begin
         next_sy_off = 1'b1; // see R12
      end
      // per cycle limit holds the switch off until next cycle start
      if (il_f)
         next_cut = 1'b1; // see R07
      else if (sw_cycle_in)
         next_cut = 1'b0; // see R07
      case (state)
         lfp_pkg::LFP_OFF: begin
            next_oc_cnt = '0;
            if (en_f && !shutdown)
               next_state = lfp_pkg::LFP_DETECT;
         end
         lfp_pkg::LFP_DETECT: begin
            // open strings found before boost starts stay out
            next_dropped = so_f;
            if (dd_f)
               next_state = lfp_pkg::LFP_RUN; // see R06
            // the 2x input limit is armed in detect as well as run, even before boost starts
            if (o2_f)
               next_state = lfp_pkg::LFP_LATCH; // see R14
         end
         lfp_pkg::LFP_RUN: begin
            // an open string behind an overvoltage leaves regulation
            if (ov_f)
               next_dropped = dropped | so_f; // see R02
            if (o1_f && sw_cycle_in)
               next_oc_cnt = oc_cnt + 1'b1; // see R09
            else if (!o1_f)
               next_oc_cnt = '0; // see R11
            if (sn_f || i2_f || o2_f ||
                (o1_f && oc_cnt >= OW'(OC1_CYCLES)))
               next_state = lfp_pkg::LFP_LATCH; // see R04 R08 R14 R18
         end
         default: begin
            // held until a shutdown clears it
         end
      endcase
      if (shutdown) begin
         next_state = lfp_pkg::LFP_OFF; // see R05 R16
         next_dropped = '0;
         next_oc_cnt = '0;
      end
   end

   // output decode from next state, so outputs stay registered
   always_comb begin
      logic run;
      run = (next_state == lfp_pkg::LFP_RUN) && !next_sy_off && en_f;
      next_boost = run && !next_ov_f && !next_cut && !next_il_f; // see R01 R03
      next_sinks = run ? ~next_dropped : '0;
      next_disc = (next_state == lfp_pkg::LFP_DETECT ||
                   next_state == lfp_pkg::LFP_RUN) && !next_sy_off; // see R12
      next_cc = next_disc && (next_state == lfp_pkg::LFP_RUN) && next_o1_f;
      // fault flag kept active low in its flop so the pin needs no gate
      next_flt_n = !((next_state == lfp_pkg::LFP_LATCH) ||
                     next_cc); // see R10 R11 R15
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state <= lfp_pkg::LFP_OFF;
         en_cnt <= '0;
         oc_cnt <= '0;
         uv_cnt <= '0;
         sy_cnt <= '0;
         dropped <= '0;
         lp <= 1'b0;
         uv_off <= 1'b0;
         sy_off <= 1'b0;
         cut <= 1'b0;
         boost <= 1'b0;
         sinks <= '0;
         disc <= 1'b0;
         cc <= 1'b0;
         flt_n <= 1'b1;
      end else begin
         state <= next_state;
         en_cnt <= next_en_cnt;
         oc_cnt <= next_oc_cnt;
         uv_cnt <= next_uv_cnt;
         sy_cnt <= next_sy_cnt;
         dropped <= next_dropped;
         lp <= next_lp;
         uv_off <= next_uv_off;
         sy_off <= next_sy_off;
         cut <= next_cut;
         boost <= next_boost;
         sinks <= next_sinks;
         disc <= next_disc;
         cc <= next_cc;
         flt_n <= next_flt_n;
      end
   end

   assign boost_gate_en_out = boost;
   assign led_sink_pins_en_out = sinks;
   assign disconnect_on_out = disc;
   assign disconnect_cc_out = cc;
   assign fault_n_out = flt_n;
   assign low_power_out = lp;

   // checks
   a_ovp_stops_boost: assert property ( // see R01
      @(posedge clk_in) disable iff (sys_rst_in) ov_f |-> !boost)
      else $error("boost ran during overvoltage");
   a_sn_latches: assert property ( // see R04
      @(posedge clk_in) disable iff (sys_rst_in)
      sn_f && state == lfp_pkg::LFP_RUN
      |=> state == lfp_pkg::LFP_LATCH || $past(shutdown))
      else $error("switch node overvoltage not latched");
   a_latch_holds: assert property ( // see R05
      @(posedge clk_in) disable iff (sys_rst_in)
      state == lfp_pkg::LFP_LATCH && !shutdown
      |=> state == lfp_pkg::LFP_LATCH)
      else $error("latch left without shutdown");
   a_latch_outs_off: assert property ( // see R15
      @(posedge clk_in) disable iff (sys_rst_in)
      state == lfp_pkg::LFP_LATCH
      |-> !boost && sinks == '0 && !disc && !flt_n)
      else $error("latched outputs wrong");
   a_detect_first: assert property ( // see R06
      @(posedge clk_in) disable iff (sys_rst_in)
      state == lfp_pkg::LFP_DETECT |-> !boost)
      else $error("boost before detection");
   a_cut_cycle: assert property ( // see R07
      @(posedge clk_in) disable iff (sys_rst_in) il_f |=> !boost)
      else $error("switch on past current limit");
   a_fault_1x: assert property ( // see R10
      @(posedge clk_in) disable iff (sys_rst_in) cc |-> !fault_n_out)
      else $error("fault not shown in 1x mode");
   a_sync_off: assert property ( // see R12
      @(posedge clk_in) disable iff (sys_rst_in)
      sy_off |-> !disc && !boost)
      else $error("sync shutdown ignored");
   a_uv_filter: assert property ( // see R17
      @(posedge clk_in) disable iff (sys_rst_in)
      $rose(uv_off) |-> $past(uv_f) && $past(uv_cnt) == UW'(UV_CYCLES))
      else $error("undervoltage not filtered");
   // the 2x deadline also covers a start-up that never finishes detection
   a_oc2_off: assert property ( // see R14
      @(posedge clk_in) disable iff (sys_rst_in)
      o2_f |-> ##[1:OC2_LIM] !disc)
      else $error("2x overcurrent did not shut down");
   c_latch: cover property (@(posedge clk_in) state == lfp_pkg::LFP_LATCH);
   c_lp: cover property (@(posedge clk_in) $rose(lp));
   c_cc: cover property (@(posedge clk_in) $fell(cc) && flt_n);
endmodule

// File: testbench/lfp_host_model.sv
// host model: drives the enable pin and a free running sync clock
`timescale 1ns/1ns
module lfp_host_model (
   // clock
   input wire logic clk_in,
   // requests from the bench
   input wire logic en_req_in,
   input wire logic sync_stop_in,
   // host pins
   output logic enable_dim_pin_out,
   output logic freq_set_sync_pin_out
);
   logic [2:0] div = 3'h0;

   // pins move only on the edge, so the device never sees a mid-cycle glitch
   always_ff @(posedge clk_in) begin
      div <= div + 3'h1;
      // a stop request parks the sync pin low
      freq_set_sync_pin_out <= !sync_stop_in && div[2];
      // enable held low long enough clears a latch, as does a filtered undervoltage
      enable_dim_pin_out <= en_req_in;
   end
endmodule

// File: testbench/test_lfp_fault_ctrl.sv
// self-checking bench for the fault protection sequencer
`timescale 1ns/1ns
module test_lfp_fault_ctrl;
   localparam int B = 0, D = 1, F = 2, C = 3, L = 4;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic overvoltage_sense_input = 1'b0, swn = 1'b0, ilim = 1'b0, ilim2 = 1'b0;
   logic oc1 = 1'b0, oc2 = 1'b0, uv = 1'b0, det = 1'b0;
   logic en_req = 1'b0, sync_stop = 1'b0;
   logic [3:0] opn = 4'h0;
   logic [1:0] sw_cnt = 2'h0;
   logic en_pin, sync_pin, boost, disc_on, disc_cc, fault_n, low_pw;
   logic [3:0] sinks;
   int checked = 0;
   int mismatches = 0;

   always #5 clk_in = !clk_in;
   // switching cycle pulse every fourth clock keeps the long counts short
   always @(posedge clk_in) sw_cnt <= #1 sw_cnt + 2'h1;

   lfp_host_model host (.clk_in(clk_in), .en_req_in(en_req),
      .sync_stop_in(sync_stop), .enable_dim_pin_out(en_pin),
      .freq_set_sync_pin_out(sync_pin));

   lfp_fault_ctrl #(.EN_LOW_CYCLES(20), .OC1_CYCLES(10), .UV_CYCLES(20)) dut (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .sw_cycle_in(sw_cnt == 2'h0), .enable_dim_pin_in(en_pin),
      .freq_set_sync_pin_in(sync_pin), .ovp_trip_in(overvoltage_sense_input),
      .switch_node_ovp_in(swn), .sw_ilim_in(ilim), .sw_ilim2_in(ilim2),
      .in_oc1x_in(oc1), .in_oc2x_in(oc2), .uv_fall_in(uv),
      .string_open_in(opn), .detect_done_in(det),
      .boost_gate_en_out(boost), .led_sink_pins_en_out(sinks),
      .disconnect_on_out(disc_on), .disconnect_cc_out(disc_cc),
      .fault_n_out(fault_n), .low_power_out(low_pw));

   function automatic logic probe(input int sel);
      case (sel)
         B: probe = boost;
         D: probe = disc_on;
         F: probe = fault_n;
         C: probe = disc_cc;
         default: probe = low_pw;
      endcase
   endfunction

   task automatic test_done;
      $display("checks %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic fail(input string m);
      mismatches++;
      $display("Error at %0t: %s", $time, m);
   endtask

   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      checked++;
      if (got !== exp) fail("sink enables wrong");
   endtask

   // bounded wait on one output; a zero limit is a plain compare
   task automatic await(input int sel, input logic v, input int lim);
      int n;
      checked++;
      n = 0;
      while (probe(sel) !== v && n < lim) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      if (probe(sel) !== v) begin
         fail("output did not reach its level in time");
         test_done();
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic bring_up;
      det = 1'b0;
      en_req = 1'b1;
      await(D, 1'b1, 30);
      tick(6);
      await(B, 1'b0, 0);
      det = 1'b1;
      await(B, 1'b1, 20);
      $display("bring-up done");
   endtask

   task automatic shutdown;
      en_req = 1'b0;
      det = 1'b0;
      tick(40);
      await(L, 1'b0, 0);
      await(L, 1'b1, 110);
      await(F, 1'b1, 2);
      $display("shutdown done");
   endtask

   task automatic t_ovp_ilim;
      opn = 4'h2;
      overvoltage_sense_input = 1'b1;
      await(B, 1'b0, 8);
      tick(4);
      overvoltage_sense_input = 1'b0;
      opn = 4'h0;
      await(B, 1'b1, 12);
      chk(sinks, 4'hD);
      ilim = 1'b1;
      await(B, 1'b0, 8);
      ilim = 1'b0;
      await(B, 1'b1, 12);
      $display("overvoltage and cycle limit done");
   endtask

   task automatic t_oc1;
      oc1 = 1'b1;
      await(F, 1'b0, 8);
      await(C, 1'b1, 2);
      oc1 = 1'b0;
      await(F, 1'b1, 10);
      await(C, 1'b0, 4);
      await(B, 1'b1, 8);
      oc1 = 1'b1;
      await(C, 1'b1, 8);
      tick(20);
      await(D, 1'b1, 0);
      await(D, 1'b0, 60);
      await(B, 1'b0, 0);
      chk(sinks, 4'h0);
      oc1 = 1'b0;
      tick(10);
      await(F, 1'b0, 0);
      $display("input overcurrent 1x done");
   endtask

   task automatic t_sync;
      sync_stop = 1'b1;
      // the watchdog needs 7 us, about 700 clocks, of steady low
      tick(600);
      await(B, 1'b1, 0);
      await(D, 1'b1, 0);
      await(D, 1'b0, 150);
      await(B, 1'b0, 0);
      chk(sinks, 4'h0);
      sync_stop = 1'b0;
      await(B, 1'b1, 60);
      $display("sync stop done");
   endtask

   task automatic t_swnode;
      swn = 1'b1;
      await(D, 1'b0, 8);
      await(B, 1'b0, 0);
      chk(sinks, 4'h0);
      swn = 1'b0;
      // detection left pending, so the restart after the clear waits
      det = 1'b0;
      uv = 1'b1;
      tick(10);
      uv = 1'b0;
      tick(10);
      await(F, 1'b0, 0);
      await(D, 1'b0, 0);
      uv = 1'b1;
      tick(30);
      uv = 1'b0;
      await(F, 1'b1, 10);
      en_req = 1'b0;
      tick(4);
      $display("switch node overvoltage done");
   endtask

   task automatic t_hard;
      ilim2 = 1'b1;
      await(B, 1'b0, 8);
      await(D, 1'b0, 0);
      ilim2 = 1'b0;
      tick(10);
      await(D, 1'b0, 0);
      shutdown();
      bring_up();
      oc2 = 1'b1;
      await(D, 1'b0, 300);
      await(F, 1'b0, 0);
      oc2 = 1'b0;
      tick(10);
      await(B, 1'b0, 0);
      $display("hard shutdowns done");
   endtask

   initial begin
      tick(10);
      sys_rst_in = 1'b0;
      bring_up();
      t_ovp_ilim();
      t_oc1();
      shutdown();
      bring_up();
      t_sync();
      t_swnode();
      bring_up();
      t_hard();
      shutdown();
      test_done();
   end
endmodule
